// ### hw/adc_mon_consts.svh
`ifndef ADC_MON_CONSTS_SVH
`define ADC_MON_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address is 4x)
// ----------------------------------------
`define IDX_RES_LO 8'h78
`define IDX_RES_HI 8'h79
`define IDX_CTRL_A 8'h7a
`define IDX_CTRL_B 8'h7b
`define IDX_IN_SEL 8'h7c
`define IDX_CTRL_C 8'h7d
`define IDX_PIN_OFF0 8'h7e
`define IDX_PIN_OFF1 8'h7f
`define IDX_OFS0 8'ha3
`define IDX_OFS1 8'ha4
`define IDX_LOW_LO 8'ha5
`define IDX_LOW_HI 8'ha6
`define IDX_HIGH_LO 8'haa
`define IDX_HIGH_HI 8'hab
`define IDX_MON_SC 8'hac
`define IDX_CTRL_D 8'had
`define IDX_DIFF_AMP 8'hdc

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL_A 8'h05
`define RST_CTRL_C 8'h01
`define RST_MON_SC 8'h01
`define RST_ZERO 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define A_EN 7
`define A_START 6
`define A_ATE 5
`define A_FLAG 4
`define C_COMP 7
`define C_POL 5
`define C_MON 4
`define IS_LEFT 5
`define MS_KIND 4

// ----------------------------------------
// Timing and range constants
// ----------------------------------------
`define CONV_TICKS 4'he
`define TAP_FOUR_FIFTHS 5'h0c
`define TAP_ONE_FIFTH 5'h0d
`define RES_MAX 12'hfff
`define COMP_SPLIT 12'h800
`define DIV_SRC_FIRST 3'h1
`define DIV_SRC_LAST 3'h6

`endif

// ### hw/adc_mon_pkg.sv
package adc_mon_pkg;

  // Controls presented to the analog core, divider and multiplexer
  typedef struct packed {
    logic conv_on;
    logic sample;
    logic busy;
    logic polarity_swap;
    logic [4:0] channel;
    logic [1:0] ref_sel;
    logic div_on;
    logic [2:0] divider_source;
    logic [1:0] tap_sel;
  } ana_ctrl_t;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } conv_state_t;

endpackage

// ### hw/adc_monitor_offset_control.sv
`timescale 1ns/1ps
`include "adc_mon_consts.svh"
// Operation
// - Range event raised only after filter_count consecutive out-of-range results, all but the last of one kind
// - Setting monitor_enable aborts conversion, idles sequencer, then starts auto conversions
// - Sixteen-bit underflow limit held in low and high bytes
// - Sixteen-bit overflow limit held in low and high bytes
// - Clearing monitor_enable stops monitoring at any time
// - Divider input selected from inputs 0,1,4,5, reference pin or supply
// - Divider four-fifths and one-fifth taps appear as channels 12 and 13
// - Polarity bit reverses comparator input polarity
// - Offsets and their arithmetic are signed two's complement
// - With compensation on, results adjusted by offsets before data registers
// - Right alignment: bits 7..0 low byte, bits 11..8 high byte low nibble
// - Left alignment: bits 11..4 high byte, bits 3..0 low byte upper nibble
// - Converter enabled only while conv_enable is one
// - Start begins one conversion, or the first of a continuous run
// - Monitor status and control C reset to 0x01, control A to 0x05, others 0x00
// - Range event after filter_count out-of-range results sets interrupt flag and stops monitoring at once
// - Status bit records overflow versus underflow of latest event
// - Conversion takes 15 converter clocks until result and flag
module adc_monitor_offset_control #(
  parameter int AW = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [11:0] raw_result_i,
  input wire logic [7:0] trig_i,
  output adc_mon_pkg::ana_ctrl_t ana_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic ack_q;
  logic [7:0] rd_q;
  logic [7:0] res_lo_q, res_hi_q, ctrl_a_q, ctrl_b_q, in_sel_q, ctrl_c_q;
  logic [7:0] pin_off0_q, pin_off1_q, ofs0_q, ofs1_q, mon_sc_q, ctrl_d_q, diff_amp_q;
  logic [15:0] low_limit_q, high_limit_q;
  adc_mon_pkg::conv_state_t state_q;
  logic [3:0] cnt_q;
  logic [6:0] pre_q;
  logic start_pend_q, cont_run_q, trig_prev_q;
  logic [4:0] chan_q;
  logic [1:0] ref_q;
  logic pol_q;
  logic [3:0] agree_q;
  logic last_kind_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0] idx;
  logic acc, wr, rd_pend;
  logic [7:0] wd;
  assign idx = adr_i[9:2];
  assign acc = cyc_i & stb_i;
  assign wr = acc & ack_q & we_i & sel_i[0];
  assign rd_pend = acc & ~ack_q;
  assign wd = dat_i[7:0];
  assign ack_o = ack_q;
  assign dat_o = {24'h000000, rd_q};

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  logic en, tick, ate, done, begin_conv, mon_en, mon_set, trig_edge, trig_sel;
  logic [6:0] pre_top;
  assign en = ctrl_a_q[`A_EN];
  assign ate = ctrl_a_q[`A_ATE];
  assign mon_en = ctrl_c_q[`C_MON];
  assign mon_set = wr & (idx == `IDX_CTRL_C) & wd[`C_MON] & ~mon_en;
  assign pre_top = (ctrl_a_q[2:0] == 3'h0) ? 7'h01 : 7'((8'h01 << ctrl_a_q[2:0]) - 8'h01);
  assign tick = en & (pre_q == pre_top);
  assign trig_sel = trig_i[ctrl_b_q[2:0]];
  assign trig_edge = ate & (ctrl_b_q[2:0] != 3'h0) & trig_sel & ~trig_prev_q;
  assign done = (state_q == adc_mon_pkg::ST_CONV) & tick & (cnt_q == `CONV_TICKS);
  assign begin_conv = (state_q == adc_mon_pkg::ST_IDLE) & tick & ~mon_set
    & (start_pend_q | mon_en | cont_run_q);

  // Prescaler runs only while the converter is on
  always_ff @(posedge clk_i) begin
    if (rst_i || !en || tick) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // Trigger source history for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
    end
  end

  // Sequencer: idle, then 15 converter clocks
  always_ff @(posedge clk_i) begin
    if (rst_i || !en || mon_set) begin
      state_q <= adc_mon_pkg::ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        adc_mon_pkg::ST_IDLE: begin
          if (begin_conv) begin
            state_q <= adc_mon_pkg::ST_CONV;
            cnt_q <= 4'h0;
          end
        end
        adc_mon_pkg::ST_CONV: begin
          if (done) begin
            state_q <= adc_mon_pkg::ST_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= adc_mon_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pending start; enable and start may come in the same write
  always_ff @(posedge clk_i) begin
    if (rst_i || mon_set || begin_conv) begin
      start_pend_q <= 1'b0;
    end else if (wr && idx == `IDX_CTRL_A && wd[`A_START] && wd[`A_EN]) begin
      start_pend_q <= 1'b1;
    end else if (!en) begin
      start_pend_q <= 1'b0;
    end else if (trig_edge && state_q == adc_mon_pkg::ST_IDLE) begin
      start_pend_q <= 1'b1;
    end
  end

  // Continuous mode repeats after the first conversion
  always_ff @(posedge clk_i) begin
    if (rst_i || !en || !ate || ctrl_b_q[2:0] != 3'h0) begin
      cont_run_q <= 1'b0;
    end else if (done) begin
      cont_run_q <= 1'b1;
    end
  end

  // Channel, reference and polarity held through a conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= 5'h00;
      ref_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (state_q == adc_mon_pkg::ST_IDLE) begin
      chan_q <= in_sel_q[4:0];
      ref_q <= in_sel_q[7:6];
      pol_q <= ctrl_c_q[`C_POL];
    end
  end

  // ----------------------------------------
  // Offset compensation
  // ----------------------------------------
  logic signed [13:0] sum;
  logic [7:0] ofs_sel;
  logic [11:0] comp;
  assign ofs_sel = (raw_result_i >= `COMP_SPLIT) ? ofs0_q : ofs1_q;
  assign sum = $signed({2'b00, raw_result_i}) + 14'($signed(ofs_sel));
  always_comb begin
    if (!ctrl_c_q[`C_COMP]) begin
      comp = raw_result_i;
    end else if (sum < 14'sd0) begin
      comp = 12'h000;
    end else if (sum > $signed({2'b00, `RES_MAX})) begin
      comp = `RES_MAX;
    end else begin
      comp = sum[11:0];
    end
  end

  // ----------------------------------------
  // Monitor comparison and filter
  // ----------------------------------------
  logic over, under, hit, kind, fire;
  logic [3:0] need;
  assign over = {4'h0, comp} > high_limit_q;
  assign under = {4'h0, comp} < low_limit_q;
  assign hit = over | under;
  assign kind = over;
  assign need = (mon_sc_q[3:0] == 4'h0) ? 4'h1 : mon_sc_q[3:0];
  assign fire = done & mon_en & hit & (((agree_q + 4'h1) >= need) | (need == 4'h1));

  // Consecutive agreement counter
  always_ff @(posedge clk_i) begin
    if (rst_i || mon_set || !mon_en) begin
      agree_q <= 4'h0;
      last_kind_q <= 1'b0;
    end else if (done) begin
      if (!hit || fire) begin
        agree_q <= 4'h0;
      end else if (agree_q == 4'h0 || kind == last_kind_q) begin
        agree_q <= agree_q + 4'h1;
      end else begin
        agree_q <= 4'h1;
      end
      last_kind_q <= kind;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Control A: enable, start, auto-trigger, flag, prescale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_q <= `RST_CTRL_A;
    end else begin
      if (wr && idx == `IDX_CTRL_A) begin
        ctrl_a_q[7] <= wd[7];
        ctrl_a_q[5] <= wd[5];
        ctrl_a_q[3:0] <= wd[3:0];
      end
      ctrl_a_q[`A_START] <= 1'b0;
      if (done) begin
        ctrl_a_q[`A_FLAG] <= 1'b1;
      end else if (wr && idx == `IDX_CTRL_A && wd[`A_FLAG]) begin
        ctrl_a_q[`A_FLAG] <= 1'b0;
      end
    end
  end

  // Control C: compensation, polarity, monitor enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_c_q <= `RST_CTRL_C;
    end else begin
      if (wr && idx == `IDX_CTRL_C) begin
        ctrl_c_q <= wd & 8'hb7;
      end
      if (fire) begin
        ctrl_c_q[`C_MON] <= 1'b0;
      end
    end
  end

  // Monitor status and control: filter count and event kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_sc_q <= `RST_MON_SC;
    end else begin
      if (wr && idx == `IDX_MON_SC) begin
        mon_sc_q[3:0] <= wd[3:0];
      end
      if (fire) begin
        mon_sc_q[`MS_KIND] <= kind;
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_b_q <= `RST_ZERO;
      in_sel_q <= `RST_ZERO;
      pin_off0_q <= `RST_ZERO;
      pin_off1_q <= `RST_ZERO;
      ofs0_q <= `RST_ZERO;
      ofs1_q <= `RST_ZERO;
      ctrl_d_q <= `RST_ZERO;
      diff_amp_q <= `RST_ZERO;
      low_limit_q <= 16'h0000;
      high_limit_q <= 16'h0000;
    end else if (wr) begin
      case (idx)
        `IDX_CTRL_B: ctrl_b_q <= wd;
        `IDX_IN_SEL: in_sel_q <= wd;
        `IDX_PIN_OFF0: pin_off0_q <= wd;
        `IDX_PIN_OFF1: pin_off1_q <= wd;
        `IDX_OFS0: ofs0_q <= wd;
        `IDX_OFS1: ofs1_q <= wd;
        `IDX_LOW_LO: low_limit_q[7:0] <= wd;
        `IDX_LOW_HI: low_limit_q[15:8] <= wd;
        `IDX_HIGH_LO: high_limit_q[7:0] <= wd;
        `IDX_HIGH_HI: high_limit_q[15:8] <= wd;
        `IDX_CTRL_D: ctrl_d_q <= wd & 8'hf7;
        `IDX_DIFF_AMP: diff_amp_q <= wd;
        default: begin
        end
      endcase
    end
  end

  // Result bytes, aligned at completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_lo_q <= `RST_ZERO;
      res_hi_q <= `RST_ZERO;
    end else if (done) begin
      if (in_sel_q[`IS_LEFT]) begin
        res_hi_q <= comp[11:4];
        res_lo_q <= {comp[3:0], 4'h0};
      end else begin
        res_lo_q <= comp[7:0];
        res_hi_q <= {4'h0, comp[11:8]};
      end
    end
  end

  // Read data captured in the cycle before ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= `RST_ZERO;
    end else if (rd_pend) begin
      case (idx)
        `IDX_RES_LO: rd_q <= res_lo_q;
        `IDX_RES_HI: rd_q <= res_hi_q;
        `IDX_CTRL_A: rd_q <= ctrl_a_q | {1'b0, start_pend_q | (state_q == adc_mon_pkg::ST_CONV), 6'h00};
        `IDX_CTRL_B: rd_q <= ctrl_b_q;
        `IDX_IN_SEL: rd_q <= in_sel_q;
        `IDX_CTRL_C: rd_q <= ctrl_c_q;
        `IDX_PIN_OFF0: rd_q <= pin_off0_q;
        `IDX_PIN_OFF1: rd_q <= pin_off1_q;
        `IDX_OFS0: rd_q <= ofs0_q;
        `IDX_OFS1: rd_q <= ofs1_q;
        `IDX_LOW_LO: rd_q <= low_limit_q[7:0];
        `IDX_LOW_HI: rd_q <= low_limit_q[15:8];
        `IDX_HIGH_LO: rd_q <= high_limit_q[7:0];
        `IDX_HIGH_HI: rd_q <= high_limit_q[15:8];
        `IDX_MON_SC: rd_q <= mon_sc_q;
        `IDX_CTRL_D: rd_q <= ctrl_d_q;
        `IDX_DIFF_AMP: rd_q <= diff_amp_q;
        default: rd_q <= `RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Analog side controls
  // ----------------------------------------
  logic div_ok;
  assign div_ok = (ctrl_d_q[2:0] >= `DIV_SRC_FIRST) && (ctrl_d_q[2:0] <= `DIV_SRC_LAST);
  always_comb begin
    ana_o.conv_on = en;
    ana_o.sample = begin_conv;
    ana_o.busy = (state_q == adc_mon_pkg::ST_CONV);
    ana_o.polarity_swap = pol_q;
    ana_o.channel = chan_q;
    ana_o.ref_sel = ref_q;
    ana_o.div_on = div_ok;
    ana_o.divider_source = div_ok ? ctrl_d_q[2:0] : 3'h0;
    ana_o.tap_sel = {chan_q == `TAP_ONE_FIFTH, chan_q == `TAP_FOUR_FIFTHS};
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CONV_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
    done |=> ctrl_a_q[`A_FLAG] && state_q == adc_mon_pkg::ST_IDLE && $past(cnt_q) == 4'he)
    else $error("conversion length wrong");
  AST_MON_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && mon_en && hit && need == 4'h1) |=> !ctrl_c_q[`C_MON] && ctrl_a_q[`A_FLAG])
    else $error("monitor did not stop on event");
  AST_FILTER_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && mon_en && hit && need > 4'h1 && agree_q == 4'h0 && !mon_set
      && !(wr && idx == `IDX_CTRL_C)) |=> ctrl_c_q[`C_MON])
    else $error("event raised before filter count");
  AST_MON_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_set |=> state_q == adc_mon_pkg::ST_IDLE && !start_pend_q)
    else $error("monitor enable did not abort");
  AST_EN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !en |=> state_q == adc_mon_pkg::ST_IDLE && pre_q == 7'h00)
    else $error("converter ran while disabled");
  AST_RIGHT_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && !in_sel_q[`IS_LEFT]) |=> res_hi_q[7:4] == 4'h0 && {res_hi_q[3:0], res_lo_q} == $past(comp))
    else $error("right alignment wrong");
  AST_LEFT_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (done && in_sel_q[`IS_LEFT]) |=> res_lo_q[3:0] == 4'h0 && {res_hi_q, res_lo_q[7:4]} == $past(comp))
    else $error("left alignment wrong");
  AST_SATURATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_c_q[`C_COMP] && sum < 14'sd0) |-> comp == 12'h000)
    else $error("compensation wrapped below zero");
  AST_LOW_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IDX_LOW_LO) |=> low_limit_q[7:0] == $past(wd))
    else $error("low limit not written");
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IDX_CTRL_A && wd[`A_START] && wd[`A_EN] && en && !mon_en
      && state_q == adc_mon_pkg::ST_IDLE) |-> ##[1:260] ana_o.busy)
    else $error("start did not begin conversion");
  AST_KIND: assert property (@(posedge clk_i) disable iff (rst_i)
    fire |=> mon_sc_q[`MS_KIND] == $past(over))
    else $error("event kind not recorded");

endmodule

// ### sim/adc_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Analog core stand-in
// ----------------------------------------
module adc_core_model #(
  parameter int OFS = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire adc_mon_pkg::ana_ctrl_t ctrl_i,
  input wire logic [11:0] level_i,
  output logic [11:0] raw_o
);
  logic [11:0] hold_q;

  // Reading taken at the sample pulse, comparator offset sign follows polarity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 12'h000;
    end else if (ctrl_i.sample) begin
      hold_q <= ctrl_i.polarity_swap ? level_i + 12'(OFS) : level_i - 12'(OFS);
    end
  end

  // Outside a conversion the line shows the inverse, never a stale good value
  assign raw_o = ctrl_i.busy ? hold_q : ~hold_q;
endmodule

// ### sim/adc_monitor_offset_control_tb_top.sv
`timescale 1ns/1ps
`include "adc_mon_consts.svh"
module adc_monitor_offset_control_tb_top;
  localparam int OFS = 3;
  localparam logic [7:0] RIDX [17] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'ha3,
    8'ha4, 8'ha5, 8'ha6, 8'haa, 8'hab, 8'hac, 8'had, 8'hdc};
  localparam logic [7:0] REXP [17] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] RWIDX [6] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'haa, 8'hab};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] wb_adr = 10'h000;
  logic [31:0] wb_dat = 32'h0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [7:0] trig = 8'h00;
  logic [11:0] level = 12'h000;
  logic [31:0] rd_dat;
  logic ack;
  logic [11:0] raw;
  adc_mon_pkg::ana_ctrl_t ana;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 63135;
  int run_len = 0;
  int last_len = 0;
  int conv_cnt = 0;
  int n_sample = 0;
  int b;
  int n;
  logic [7:0] q;
  logic [7:0] d;
  logic [7:0] o0;
  logic [7:0] o1;
  logic [11:0] r;
  logic [11:0] pv;
  logic [11:0] nv;
  logic [4:0] ch;

  adc_monitor_offset_control u_adc_monitor_offset_control (.clk_i(clk_i), .rst_i(rst_i), .adr_i(wb_adr),
    .dat_i(wb_dat), .dat_o(rd_dat), .we_i(wb_we), .sel_i(wb_sel), .cyc_i(wb_cyc), .stb_i(wb_stb),
    .ack_o(ack), .raw_result_i(raw), .trig_i(trig), .ana_o(ana));
  adc_core_model #(.OFS(OFS)) u_adc_core_model (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ana),
    .level_i(level), .raw_o(raw));

  // Clock and watchdog
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end

  // Busy run length and completed conversion count
  always @(posedge clk_i) begin
    if (ana.busy === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
      conv_cnt <= conv_cnt + 1;
    end
  end

  // Start pulses seen by the core
  always @(posedge clk_i) begin
    if (ana.sample === 1'b1) begin
      n_sample <= n_sample + 1;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_adr <= {idx, 2'b00};
    wb_we <= w;
    wb_dat <= {24'h0, wd};
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 100);
    q = rd_dat[7:0];
    check(16'(k < 100), 16'h1, "bus answer");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic conv_wait(input int want);
    int k;
    k = 0;
    while (conv_cnt < want && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    check(16'(k < 20000), 16'h1, "conversion end");
  endtask

  task automatic convert(input logic [7:0] isel, input logic [7:0] cc, output logic [11:0] res);
    logic [7:0] lo;
    int bb;
    int bs;
    bb = conv_cnt;
    bs = n_sample;
    wb(`IDX_IN_SEL, 1'b1, isel);
    wb(`IDX_CTRL_C, 1'b1, cc);
    wb(`IDX_CTRL_A, 1'b1, 8'hd0);
    conv_wait(bb + 1);
    check(16'(last_len), 16'd30, "conversion length");
    check(16'(conv_cnt - bb), 16'h1, "single conversion");
    check(16'(ana.channel), 16'(isel[4:0]), "channel latch");
    check(16'(ana.ref_sel), 16'(isel[7:6]), "reference latch");
    check(16'(n_sample - bs), 16'h1, "start pulse");
    wb(`IDX_RES_LO, 1'b0, 8'h00);
    lo = q;
    wb(`IDX_RES_HI, 1'b0, 8'h00);
    res = isel[5] ? {q, lo[7:4]} : {q[3:0], lo};
  endtask

  function automatic logic [11:0] comp(input logic [11:0] rw, input logic [7:0] a, input logic [7:0] c);
    int s;
    s = int'(rw) + ((rw >= 12'h800) ? int'(signed'(a)) : int'(signed'(c)));
    return (s < 0) ? 12'h000 : ((s > 4095) ? 12'hfff : 12'(s));
  endfunction

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      wb(RIDX[i], 1'b0, 8'h00);
      check(16'(q), 16'(REXP[i]), "reset value");
    end
    wb(8'h80, 1'b1, 8'hff);
    wb(8'h80, 1'b0, 8'h00);
    check(16'(q), 16'h0, "unmapped");
    wb(`IDX_RES_LO, 1'b1, 8'hff);
    wb(`IDX_RES_LO, 1'b0, 8'h00);
    check(16'(q), 16'h0, "read only");
    end_test("reset");
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wb(RWIDX[i], 1'b1, d);
      wb(RWIDX[i], 1'b0, 8'h00);
      check(16'(q), 16'(d), "limit or offset");
    end
    for (int c = 0; c < 8; c++) begin
      wb(`IDX_CTRL_D, 1'b1, 8'(c));
      @(posedge clk_i);
      check(16'(ana.div_on), 16'(c >= 1 && c <= 6), "divider on");
      check(16'(ana.divider_source), 16'((c >= 1 && c <= 6) ? c : 0), "divider source");
    end
    end_test("registers");
    level <= 12'({$random(seed)} % 4000) + 12'h010;
    for (int a = 0; a < 2; a++) begin
      ch = 5'({$random(seed)} % 12);
      convert({2'b01, a[0], ch}, 8'h01, r);
      check(16'(r), 16'(level - 12'(OFS)), "aligned result");
    end
    convert({3'b010, ch}, 8'h20, nv);
    check(16'(ana.polarity_swap), 16'h1, "polarity out");
    convert({3'b010, ch}, 8'h00, pv);
    check(16'(nv), 16'(level + 12'(OFS)), "swapped reading");
    check(16'(({1'b0, nv} + {1'b0, pv}) >> 1), 16'(level), "dynamic average");
    end_test("conversion");
    // Calibration on the divider taps with supply source and reference
    wb(`IDX_CTRL_D, 1'b1, 8'h06);
    convert(8'h4c, 8'h00, pv);
    check(16'(ana.tap_sel), 16'h1, "four fifths tap");
    convert(8'h4c, 8'h20, nv);
    o0 = 8'((int'(nv) - int'(pv)) >>> 1);
    convert(8'h4d, 8'h20, nv);
    check(16'(ana.tap_sel), 16'h2, "one fifth tap");
    convert(8'h4d, 8'h00, pv);
    o1 = 8'((int'(nv) - int'(pv)) >>> 1);
    wb(`IDX_OFS0, 1'b1, o0);
    wb(`IDX_OFS1, 1'b1, o1);
    convert(8'h43, 8'h80, r);
    check(16'(r), 16'(level), "compensated");
    wb(`IDX_OFS0, 1'b1, 8'h7f);
    wb(`IDX_OFS1, 1'b1, 8'h80);
    for (int k = 0; k < 2; k++) begin
      level <= (k == 0) ? 12'hfff : 12'h003;
      convert(8'h43, 8'h80, r);
      check(16'(r), 16'(comp(level - 12'(OFS), 8'h7f, 8'h80)), "saturation");
    end
    end_test("offset");
    wb(`IDX_CTRL_B, 1'b1, 8'h03);
    wb(`IDX_CTRL_C, 1'b1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wb(`IDX_CTRL_A, 1'b1, (k == 0) ? 8'hb0 : 8'h90);
      b = conv_cnt;
      trig <= 8'($random(seed)) | 8'h08;
      repeat (100) @(posedge clk_i);
      check(16'(conv_cnt - b), 16'((k == 0) ? 1 : 0), "auto trigger");
      trig <= 8'($random(seed)) & 8'hf7;
    end
    wb(`IDX_CTRL_B, 1'b1, 8'h00);
    b = conv_cnt;
    wb(`IDX_CTRL_A, 1'b1, 8'hf0);
    conv_wait(b + 3);
    wb(`IDX_CTRL_A, 1'b1, 8'h90);
    b = conv_cnt;
    repeat (100) @(posedge clk_i);
    check(16'(conv_cnt - b <= 1), 16'h1, "continuous stop");
    end_test("trigger");
    wb(`IDX_LOW_LO, 1'b1, 8'h00);
    wb(`IDX_LOW_HI, 1'b1, 8'h01);
    wb(`IDX_HIGH_LO, 1'b1, 8'h00);
    wb(`IDX_HIGH_HI, 1'b1, 8'h08);
    wb(`IDX_IN_SEL, 1'b1, 8'h42);
    for (int k = 0; k < 2; k++) begin
      level <= (k == 0) ? 12'h900 + 12'(OFS) : 12'h050 + 12'(OFS);
      wb(`IDX_MON_SC, 1'b1, (k == 0) ? 8'h03 : 8'h01);
      wb(`IDX_CTRL_A, 1'b1, 8'h90);
      b = conv_cnt;
      wb(`IDX_CTRL_C, 1'b1, 8'h10);
      n = 0;
      do begin
        wb(`IDX_CTRL_C, 1'b0, 8'h00);
        n++;
      end while (q[4] === 1'b1 && n < 200);
      check(16'(conv_cnt - b), 16'((k == 0) ? 3 : 1), "filter count");
      wb(`IDX_MON_SC, 1'b0, 8'h00);
      check(16'(q[4]), 16'((k == 0) ? 1 : 0), "event kind");
      wb(`IDX_CTRL_A, 1'b0, 8'h00);
      check(16'(q[4]), 16'h1, "event flag");
      b = conv_cnt;
      repeat (100) @(posedge clk_i);
      check(16'(conv_cnt - b), 16'h0, "stopped");
    end
    level <= 12'h400;
    wb(`IDX_CTRL_A, 1'b1, 8'h90);
    b = conv_cnt;
    wb(`IDX_CTRL_C, 1'b1, 8'h10);
    conv_wait(b + 5);
    wb(`IDX_CTRL_C, 1'b0, 8'h00);
    check(16'(q[4]), 16'h1, "in range keeps on");
    wb(`IDX_CTRL_C, 1'b1, 8'h00);
    b = conv_cnt;
    repeat (100) @(posedge clk_i);
    check(16'(conv_cnt - b <= 1), 16'h1, "monitor off");
    end_test("monitor");
    wb(`IDX_CTRL_A, 1'b1, 8'h00);
    @(posedge clk_i);
    check(16'(ana.conv_on), 16'h0, "converter off");
    wb(`IDX_CTRL_A, 1'b1, 8'h80);
    @(posedge clk_i);
    check(16'(ana.conv_on), 16'h1, "converter on");
    end_test("enable");
    wrap_up();
  end
endmodule
